// ==== src/dso_output_status.sv ====
// Behaviour
// - Control-channel select high makes shared pins control pins; low makes them config inputs.
// - Protocol select high picks two-wire slave, low picks UART.
// - With control pins on, shared pin is UART transmit or two-wire clock.
// - With control pins off, shared pin is edge select: high falling, low rising.
// - Power-down input low puts the block into power-down.
// - Error output shows data errors, held high while powered down.
// - Outside power-down, lock output high only with PLLs locked and word alignment correct.
// - Outside power-down, lock held low while configuration link or test pattern check runs.
// - Lock output driven high while power-down input is low.
// - Line-fault output goes low on a fault, high while powered down.
// - Top four output bits carry data after power-up and without sync encoding.
// - With sync encoding, bit 24 is upper vsync and bit 23 upper hsync.
// - With sync encoding, bit 22 is lower vsync and bit 21 lower hsync.
// - With control pins on, mode select low is base, high is bypass.
// - With control pins off, sync-encoding enable routes decoded sync onto shared outputs.
`timescale 1ns/1ns
`default_nettype none
`include "dso_cfg.svh"

module dso_output_status (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pix_clk,
  input wire logic local_ctrl_channel_sel,
  input wire logic two_wire_protocol_sel,
  input wire logic tx_clk_edge_shared_pin_in,
  output logic tx_clk_edge_shared_pin_out,
  output logic tx_clk_edge_shared_pin_oe,
  input wire logic mode_sync_shared_pin,
  input wire logic power_down_n,
  input wire logic uart_tx_bit,
  input wire logic two_wire_scl_low,
  input wire logic pll_locked,
  input wire logic word_aligned,
  input wire logic line_fault_det,
  input wire logic cfg_link_active,
  input wire logic pseudo_random_test,
  input wire logic data_err_det,
  output logic ctrl_pins_enabled,
  output logic two_wire_mode,
  output logic bypass_mode,
  output logic powered_down,
  output logic lock_status,
  output logic data_err_n,
  output logic line_fault_n,
  input wire logic [`DSO_DATA_W-1:0] rx_word,
  input wire logic rx_upper_vs,
  input wire logic rx_upper_hs,
  input wire logic rx_lower_vs,
  input wire logic rx_lower_hs,
  output logic [`DSO_LOW_W-1:0] dout_low,
  output logic bit24_upper_vsync,
  output logic bit23_upper_hsync,
  output logic bit22_lower_vsync,
  output logic bit21_lower_hsync,
  output logic parallel_out_clock
);

  // Main clock domain: pin synchronisers
  logic [`DSO_MSYNC_W-1:0] msync_q;
  logic lcc_s, i2c_s, edge_pin_s, pwd_s, mode_s, pll_s, align_s, lfd_s;

  dso_sync2 #(.W(`DSO_MSYNC_W)) u_msync (
    .clk(mclk),
    .rst(rst),
    .d({local_ctrl_channel_sel, two_wire_protocol_sel, tx_clk_edge_shared_pin_in,
        power_down_n, mode_sync_shared_pin, pll_locked, word_aligned, line_fault_det}),
    .q(msync_q)
  );

  assign {lcc_s, i2c_s, edge_pin_s, pwd_s, mode_s, pll_s, align_s, lfd_s} = msync_q;

  // Configuration capture state
  dso_pkg::dso_state_t state_ff, nxt_state;
  logic edge_cfg_ff, nxt_edge_cfg;
  logic syncen_cfg_ff, nxt_syncen_cfg;
  logic capture;

  always_comb begin
    nxt_state = state_ff;
    capture = 1'b0;
    unique case (state_ff)
      dso_pkg::DSO_ST_RESET: begin
        capture = pwd_s;
        nxt_state = pwd_s ? dso_pkg::DSO_ST_RUN : dso_pkg::DSO_ST_SLEEP;
      end
      dso_pkg::DSO_ST_RUN: begin
        if (!pwd_s) begin
          nxt_state = dso_pkg::DSO_ST_SLEEP;
        end
      end
      dso_pkg::DSO_ST_SLEEP: begin
        if (pwd_s) begin
          capture = 1'b1;
          nxt_state = dso_pkg::DSO_ST_RUN;
        end
      end
    endcase
    nxt_edge_cfg = edge_cfg_ff;
    nxt_syncen_cfg = syncen_cfg_ff;
    if (capture) begin
      // Edge select assumed static while running
      nxt_edge_cfg = !lcc_s && edge_pin_s;
      nxt_syncen_cfg = !lcc_s && mode_s;
    end
    if (rst) begin
      nxt_state = dso_pkg::DSO_ST_RESET;
      nxt_edge_cfg = `DSO_EDGE_RST;
      nxt_syncen_cfg = `DSO_SYNCEN_RST;
    end
  end

  always_ff @(posedge mclk) begin
    state_ff <= nxt_state;
    edge_cfg_ff <= nxt_edge_cfg;
    syncen_cfg_ff <= nxt_syncen_cfg;
  end

  // Status, mode and shared pin outputs
  logic pd;
  logic lock_ff, nxt_lock;
  logic err_n_ff, nxt_err_n;
  logic lfault_n_ff, nxt_lfault_n;
  logic pd_ff, nxt_pd;
  logic ccp_ff, nxt_ccp;
  logic tw_ff, nxt_tw;
  logic byp_ff, nxt_byp;
  logic pin_out_ff, nxt_pin_out;
  logic pin_oe_ff, nxt_pin_oe;

  assign pd = !pwd_s;

  always_comb begin
    nxt_pd = pd;
    nxt_lock = pd ? 1'b1 : (pll_s && align_s && !cfg_link_active && !pseudo_random_test);
    nxt_err_n = pd ? 1'b1 : !data_err_det;
    nxt_lfault_n = pd ? 1'b1 : !lfd_s;
    nxt_ccp = lcc_s;
    nxt_tw = lcc_s && i2c_s;
    nxt_byp = lcc_s && mode_s;
    // Open drain: only ever pulls low
    nxt_pin_out = 1'b0;
    if (!lcc_s) begin
      nxt_pin_oe = 1'b0;
    end else if (i2c_s) begin
      nxt_pin_oe = two_wire_scl_low;
    end else begin
      nxt_pin_oe = !uart_tx_bit;
    end
    if (rst) begin
      nxt_pd = 1'b1;
      nxt_lock = `DSO_STATUS_RST;
      nxt_err_n = `DSO_STATUS_RST;
      nxt_lfault_n = `DSO_STATUS_RST;
      nxt_ccp = 1'b0;
      nxt_tw = 1'b0;
      nxt_byp = 1'b0;
      nxt_pin_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    pd_ff <= nxt_pd;
    lock_ff <= nxt_lock;
    err_n_ff <= nxt_err_n;
    lfault_n_ff <= nxt_lfault_n;
    ccp_ff <= nxt_ccp;
    tw_ff <= nxt_tw;
    byp_ff <= nxt_byp;
    pin_out_ff <= nxt_pin_out;
    pin_oe_ff <= nxt_pin_oe;
  end

  assign powered_down = pd_ff;
  assign lock_status = lock_ff;
  assign data_err_n = err_n_ff;
  assign line_fault_n = lfault_n_ff;
  assign ctrl_pins_enabled = ccp_ff;
  assign two_wire_mode = tw_ff;
  assign bypass_mode = byp_ff;
  assign tx_clk_edge_shared_pin_out = pin_out_ff;
  assign tx_clk_edge_shared_pin_oe = pin_oe_ff;

  // Link clock domain: crossed static levels and reset
  logic [`DSO_PSYNC_W-1:0] psync_q;
  logic prst, p_edge, p_syncen, p_pd;

  dso_sync2 #(.W(`DSO_PSYNC_W)) u_psync (
    .clk(pix_clk),
    .rst(1'b0),
    .d({rst, edge_cfg_ff, syncen_cfg_ff, pd_ff}),
    .q(psync_q)
  );

  assign {prst, p_edge, p_syncen, p_pd} = psync_q;

  // Output clock toggles each link clock; data launched on the edge opposite the valid one
  logic pclk_ff, nxt_pclk;
  logic launch;
  logic blank;
  logic blank_dly_ff, nxt_blank_dly;
  logic [`DSO_LOW_W-1:0] low_ff, nxt_low;
  logic uvs_ff, nxt_uvs;
  logic uhs_ff, nxt_uhs;
  logic lvs_ff, nxt_lvs;
  logic lhs_ff, nxt_lhs;

  always_comb begin
    // Blanking held one cycle longer so the crossed config settles first
    nxt_blank_dly = prst || p_pd;
    blank = prst || p_pd || blank_dly_ff;
    nxt_pclk = blank ? 1'b0 : !pclk_ff;
    launch = !blank && (nxt_pclk == p_edge);
    nxt_low = low_ff;
    nxt_uvs = uvs_ff;
    nxt_uhs = uhs_ff;
    nxt_lvs = lvs_ff;
    nxt_lhs = lhs_ff;
    if (launch) begin
      nxt_low = rx_word[`DSO_LOW_W-1:0];
      nxt_uvs = p_syncen ? rx_upper_vs : rx_word[`DSO_UP_VS_BIT];
      nxt_uhs = p_syncen ? rx_upper_hs : rx_word[`DSO_UP_HS_BIT];
      nxt_lvs = p_syncen ? rx_lower_vs : rx_word[`DSO_LO_VS_BIT];
      nxt_lhs = p_syncen ? rx_lower_hs : rx_word[`DSO_LO_HS_BIT];
    end
    if (blank) begin
      nxt_low = `DSO_LOW_RST;
      nxt_uvs = 1'b0;
      nxt_uhs = 1'b0;
      nxt_lvs = 1'b0;
      nxt_lhs = 1'b0;
    end
  end

  always_ff @(posedge pix_clk) begin
    pclk_ff <= nxt_pclk;
    blank_dly_ff <= nxt_blank_dly;
    low_ff <= nxt_low;
    uvs_ff <= nxt_uvs;
    uhs_ff <= nxt_uhs;
    lvs_ff <= nxt_lvs;
    lhs_ff <= nxt_lhs;
  end

  assign parallel_out_clock = pclk_ff;
  assign dout_low = low_ff;
  assign bit24_upper_vsync = uvs_ff;
  assign bit23_upper_hsync = uhs_ff;
  assign bit22_lower_vsync = lvs_ff;
  assign bit21_lower_hsync = lhs_ff;

  // Checks, main clock domain
  sequence seq_pd_exit;
    state_ff == dso_pkg::DSO_ST_SLEEP && pwd_s;
  endsequence

  sequence seq_running;
    state_ff == dso_pkg::DSO_ST_RUN ##1 state_ff == dso_pkg::DSO_ST_RUN;
  endsequence

  AST_LOCK_PD: assert property (@(posedge mclk) disable iff (rst)
    !pwd_s |=> lock_status) else $error("lock not high in power-down");
  AST_LOCK_OK: assert property (@(posedge mclk) disable iff (rst)
    pwd_s && !(pll_s && align_s) |=> !lock_status) else $error("lock high without pll");
  AST_LOCK_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    pwd_s && (cfg_link_active || pseudo_random_test) |=> !lock_status)
    else $error("lock high during config link or test");
  AST_ERR_PD: assert property (@(posedge mclk) disable iff (rst)
    !pwd_s ##1 !pwd_s |-> data_err_n) else $error("error output low in power-down");
  AST_LINE_FAULT_N: assert property (@(posedge mclk) disable iff (rst)
    pwd_s && lfd_s |=> !line_fault_n) else $error("line fault not flagged");
  AST_TX_UART: assert property (@(posedge mclk) disable iff (rst)
    lcc_s && !i2c_s |=> tx_clk_edge_shared_pin_oe == !$past(uart_tx_bit))
    else $error("uart transmit not on shared pin");
  AST_PIN_INPUT: assert property (@(posedge mclk) disable iff (rst)
    !lcc_s |=> !tx_clk_edge_shared_pin_oe && !ctrl_pins_enabled)
    else $error("shared pin driven while an input");
  AST_MODE: assert property (@(posedge mclk) disable iff (rst)
    lcc_s |=> bypass_mode == $past(mode_s) && two_wire_mode == $past(i2c_s))
    else $error("mode outputs wrong");
  AST_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
    seq_pd_exit |=> edge_cfg_ff == $past(!lcc_s && edge_pin_s)
      && syncen_cfg_ff == $past(!lcc_s && mode_s)) else $error("config not captured");
  AST_CFG_STATIC: assert property (@(posedge mclk) disable iff (rst)
    seq_running |-> $stable(edge_cfg_ff) && $stable(syncen_cfg_ff))
    else $error("config changed while running");

  // Checks, link clock domain
  AST_SYNC_MAP: assert property (@(posedge pix_clk) disable iff (prst)
    launch && p_syncen |=> bit24_upper_vsync == $past(rx_upper_vs)
      && bit21_lower_hsync == $past(rx_lower_hs)) else $error("sync not routed");
  AST_DATA_MAP: assert property (@(posedge pix_clk) disable iff (prst)
    launch && !p_syncen |=> bit23_upper_hsync == $past(rx_word[`DSO_UP_HS_BIT])
      && bit22_lower_vsync == $past(rx_word[`DSO_LO_VS_BIT])) else $error("data bits wrong");
  AST_EDGE: assert property (@(posedge pix_clk) disable iff (prst)
    launch |=> parallel_out_clock == p_edge) else $error("data launched on wrong edge");

endmodule

`default_nettype wire

// ==== src/dso_cfg.svh ====
`ifndef DSO_CFG_SVH
`define DSO_CFG_SVH

// Parallel output word
`define DSO_DATA_W 25
`define DSO_LOW_W 21
`define DSO_UP_VS_BIT 24
`define DSO_UP_HS_BIT 23
`define DSO_LO_VS_BIT 22
`define DSO_LO_HS_BIT 21

// Reset values
`define DSO_LOW_RST 21'h000000
`define DSO_EDGE_RST 1'b0
`define DSO_SYNCEN_RST 1'b0
`define DSO_STATUS_RST 1'b1

// Widths of the main clock domain pin synchroniser and the link clock domain synchroniser
`define DSO_MSYNC_W 8
`define DSO_PSYNC_W 4

`endif

// ==== src/dso_pkg.sv ====
package dso_pkg;

  typedef enum logic [1:0] {
    DSO_ST_RESET,
    DSO_ST_RUN,
    DSO_ST_SLEEP
  } dso_state_t;

endpackage

// ==== src/dso_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none

module dso_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = rst ? '0 : d;
    nxt_sync = rst ? '0 : meta_ff;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign q = sync_ff;

endmodule

`default_nettype wire

// ==== verif/dso_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dso_cfg.svh"

module dso_sink (
  input wire logic out_clk,
  input wire logic edge_select,
  input wire logic [`DSO_DATA_W-1:0] word,
  output logic [`DSO_DATA_W-1:0] got
);
  // Latch on the edge chosen by edge select
  always @(out_clk) begin
    if (out_clk !== edge_select) begin
      got <= word;
    end
  end
endmodule

`default_nettype wire

// ==== verif/dso_output_status_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dso_cfg.svh"

module dso_output_status_tb;
  logic mclk = 1'b0, pix_clk = 1'b0, rst = 1'b1, sink_edge = 1'b0;
  logic local_ctrl_channel_sel = 1'b0, two_wire_protocol_sel = 1'b0;
  logic tx_clk_edge_shared_pin_in = 1'b0, mode_sync_shared_pin = 1'b0;
  logic power_down_n = 1'b1, uart_tx_bit = 1'b1, two_wire_scl_low = 1'b0;
  logic pll_locked = 1'b0, word_aligned = 1'b0, line_fault_det = 1'b0;
  logic cfg_link_active = 1'b0, pseudo_random_test = 1'b0, data_err_det = 1'b0;
  logic [24:0] rx_word = 25'h0000000, got;
  logic [3:0] syn = 4'h0;
  logic tx_clk_edge_shared_pin_out, tx_clk_edge_shared_pin_oe, ctrl_pins_enabled;
  logic two_wire_mode, bypass_mode, powered_down, lock_status, data_err_n;
  logic line_fault_n, bit24_upper_vsync, bit23_upper_hsync, bit22_lower_vsync;
  logic bit21_lower_hsync, parallel_out_clock;
  logic [20:0] dout_low;
  wire [24:0] dout = {bit24_upper_vsync, bit23_upper_hsync, bit22_lower_vsync,
    bit21_lower_hsync, dout_low};
  int failures = 0, checked = 0, cycles = 0;

  dso_output_status dut (.mclk, .rst, .pix_clk, .local_ctrl_channel_sel,
    .two_wire_protocol_sel, .tx_clk_edge_shared_pin_in, .tx_clk_edge_shared_pin_out,
    .tx_clk_edge_shared_pin_oe, .mode_sync_shared_pin, .power_down_n, .uart_tx_bit,
    .two_wire_scl_low, .pll_locked, .word_aligned, .line_fault_det, .cfg_link_active,
    .pseudo_random_test, .data_err_det, .ctrl_pins_enabled, .two_wire_mode,
    .bypass_mode, .powered_down, .lock_status, .data_err_n, .line_fault_n, .rx_word,
    .rx_upper_vs(syn[3]), .rx_upper_hs(syn[2]), .rx_lower_vs(syn[1]),
    .rx_lower_hs(syn[0]), .dout_low, .bit24_upper_vsync, .bit23_upper_hsync,
    .bit22_lower_vsync, .bit21_lower_hsync, .parallel_out_clock);

  dso_sink sink (.out_clk(parallel_out_clock), .edge_select(sink_edge), .word(dout),
    .got(got));

  always #25 mclk = ~mclk;
  initial begin
    #7;
    forever begin
      #62 pix_clk = 1'b1;
      #63 pix_clk = 1'b0;
    end
  end

  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [24:0] a, input logic [24:0] e);
    checked++;
    if (a !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic t_status;
    pll_locked <= 1'b1;
    word_aligned <= 1'b1;
    cyc(5);
    chk(lock_status, 1'b1);
    word_aligned <= 1'b0;
    cyc(5);
    chk(lock_status, 1'b0);
    word_aligned <= 1'b1;
    cfg_link_active <= 1'b1;
    cyc(5);
    chk(lock_status, 1'b0);
    cfg_link_active <= 1'b0;
    pseudo_random_test <= 1'b1;
    cyc(5);
    chk(lock_status, 1'b0);
    pseudo_random_test <= 1'b0;
    data_err_det <= 1'b1;
    line_fault_det <= 1'b1;
    cyc(5);
    chk({lock_status, data_err_n, line_fault_n}, 3'h4);
    power_down_n <= 1'b0;
    word_aligned <= 1'b0;
    cyc(5);
    chk({lock_status, data_err_n, line_fault_n, powered_down}, 4'hf);
    power_down_n <= 1'b1;
    data_err_det <= 1'b0;
    line_fault_det <= 1'b0;
    word_aligned <= 1'b1;
    cyc(5);
    chk({lock_status, data_err_n, line_fault_n, powered_down}, 4'he);
  endtask

  task automatic t_ctrl;
    local_ctrl_channel_sel <= 1'b1;
    mode_sync_shared_pin <= 1'b1;
    uart_tx_bit <= 1'b0;
    cyc(5);
    chk({ctrl_pins_enabled, two_wire_mode, bypass_mode, tx_clk_edge_shared_pin_oe,
      tx_clk_edge_shared_pin_out}, 5'h16);
    uart_tx_bit <= 1'b1;
    two_wire_scl_low <= 1'b1;
    mode_sync_shared_pin <= 1'b0;
    cyc(5);
    chk({ctrl_pins_enabled, bypass_mode, tx_clk_edge_shared_pin_oe}, 3'h4);
    two_wire_protocol_sel <= 1'b1;
    cyc(5);
    chk({two_wire_mode, tx_clk_edge_shared_pin_oe}, 2'h3);
    local_ctrl_channel_sel <= 1'b0;
    uart_tx_bit <= 1'b0;
    cyc(5);
    chk({ctrl_pins_enabled, two_wire_mode, tx_clk_edge_shared_pin_oe}, 3'h0);
    two_wire_protocol_sel <= 1'b0;
    two_wire_scl_low <= 1'b0;
    uart_tx_bit <= 1'b1;
  endtask

  // Sends one word, checks clock phase at launch and what the sink latched
  task automatic send(input logic [24:0] w, input logic [3:0] s, input logic e,
      input logic h);
    @(posedge pix_clk);
    rx_word <= w;
    syn <= s;
    for (int i = 0; i < 8 && dout_low !== w[20:0]; i++) begin
      @(posedge pix_clk);
      #1;
    end
    chk(parallel_out_clock, e);
    repeat (4) @(posedge pix_clk);
    chk(got, h ? {s, w[20:0]} : w);
  endtask

  task automatic t_data(input logic e, input logic h);
    power_down_n <= 1'b0;
    cyc(4);
    tx_clk_edge_shared_pin_in <= e;
    mode_sync_shared_pin <= h;
    sink_edge <= e;
    cyc(4);
    power_down_n <= 1'b1;
    cyc(20);
    send(25'h1a5c3e7, 4'h9, e, h);
    mode_sync_shared_pin <= ~h;
    cyc(20);
    send(25'h0e3a561, 4'h6, e, h);
  endtask

  initial begin
    cyc(10);
    chk({lock_status, data_err_n, line_fault_n, powered_down, parallel_out_clock},
      5'h1e);
    cyc(6);
    rst <= 1'b0;
    cyc(4);
    t_status();
    t_ctrl();
    t_data(1'b0, 1'b0);
    t_data(1'b1, 1'b1);
    end_of_test();
  end
endmodule

`default_nettype wire
